// >>> rtl/dacdb_top.sv
// Serial front end, input register and output latch of the converter.
// Summary of operation
// - Serial clock edges are ignored while chip select is high.
// - Chip select rising edge after sixteen or more bits copies shift register into input register.
// - One shared load strobe updates all chained output latches together.
// - Three 16-bit stages; input register loads only on valid frames.
// - Output latch alone holds the code driving the converter.
// - Strobe high keeps output latch even when input register changes.
// - Strobe low makes output latch follow the input register.
// - Strobe tied low updates output right after chip select rises.
// - Strobe high: input register write leaves output latch untouched.
// - Strobe falling loads output latch from current input register.
// - Shift serial input in on each serial clock rise while selected.
// - Frames under sixteen bits leave both registers unchanged.
// - Extra bits ripple out serially, changing on falling serial clock.
// - Serial-output select strap low selects chain mode.
`timescale 1ns/1ps
`default_nettype none
module dacdb_top (
  // System clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Serial link pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  // Load strobe and mode strap.
  input wire logic load_strobe_n,
  input wire logic serial_out_mode_select,
  // Converter code and committed-word stream.
  output logic [15:0] dac_code,
  output logic code_valid,
  input wire logic code_ready,
  output logic [15:0] code_data,
  output logic frame_drop
);
  // Reset release.
  logic [1:0] rst_sync_reg;
  logic rst_int_n;

  // Synchronisers: first stage feeds only the second.
  logic [1:0] cs_s_reg, sclk_s_reg, sdi_s_reg, ld_s_reg, sel_s_reg;
  // Delayed copies used only for edge detection.
  logic cs_d_reg, sclk_d_reg;
  logic cs_q, sclk_q, sdi_q, ld_q, sel_q;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;

  // Frame state, the three 16-bit stages and the readback copy.
  dacdb_pkg::dacdb_state_t state_reg, state_next;
  logic [15:0] shift_reg, shift_next, in_reg, in_next, latch_reg, latch_next;
  logic [15:0] ro_reg, ro_next;
  // Bit counter, serial output and drop pulse.
  logic [dacdb_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic sdo_reg, sdo_next, drop_reg, drop_next;

  // Log handshake.
  logic fifo_in_ready, fifo_push, commit;

  // Reset is released through two flops so every register leaves reset together.
  // Assertion stays asynchronous, so the block is quiet even without a clock.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_reg[1];

  // Pin synchronisers; the serial clock is sampled, not used as a clock.
  // Two stages keep a metastable sample away from the frame logic. The cost is
  // about three system cycles of lag, so each serial clock phase must last at
  // least three system cycles.
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cs_s_reg <= 2'h3;
      sclk_s_reg <= 2'h0;
      sdi_s_reg <= 2'h0;
      ld_s_reg <= 2'h3;
      sel_s_reg <= 2'h3;
      cs_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_s_reg <= {cs_s_reg[0], cs_n};
      sclk_s_reg <= {sclk_s_reg[0], sclk};
      sdi_s_reg <= {sdi_s_reg[0], sdi};
      ld_s_reg <= {ld_s_reg[0], load_strobe_n};
      sel_s_reg <= {sel_s_reg[0], serial_out_mode_select};
      cs_d_reg <= cs_s_reg[1];
      sclk_d_reg <= sclk_s_reg[1];
    end
  end
  assign cs_q = cs_s_reg[1];
  assign sclk_q = sclk_s_reg[1];
  assign sdi_q = sdi_s_reg[1];
  assign ld_q = ld_s_reg[1];
  assign sel_q = sel_s_reg[1];

  // Edges are taken between the second stage and its delayed copy.
  assign sclk_rise = sclk_q && !sclk_d_reg;
  assign sclk_fall = !sclk_q && sclk_d_reg;
  assign cs_rise = cs_q && !cs_d_reg;
  assign cs_fall = !cs_q && cs_d_reg;

  // Frame sequencing, shifting, double buffer and serial output.
  // Defaults hold every register; the commit strobe and drop pulse fall back to zero.
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    ro_next = ro_reg;
    sdo_next = sdo_reg;
    in_next = in_reg;
    drop_next = 1'b0;
    commit = 1'b0;
    case (state_reg)
      dacdb_pkg::DACDB_IDLE: begin
        if (cs_fall) begin
          // A new frame restarts the count. In readback mode the old input word is
          // copied now and its top bit goes out before the first serial clock rise.
          cnt_next = '0;
          ro_next = in_reg;
          sdo_next = sel_q ? in_reg[15] : shift_reg[15];
          state_next = dacdb_pkg::DACDB_SHIFT;
        end
      end
      dacdb_pkg::DACDB_SHIFT: begin
        // Chip select high ends shifting at once; later serial edges are ignored.
        if (cs_rise || cs_q) begin
          state_next = dacdb_pkg::DACDB_COMMIT;
        end else if (sclk_rise) begin
          shift_next = {shift_reg[14:0], sdi_q};
          ro_next = {ro_reg[14:0], 1'b0};
          // The count saturates, so long chained frames still keep the last sixteen bits.
          if (cnt_reg != dacdb_pkg::FRAME_BITS) begin
            cnt_next = cnt_reg + 1'b1;
          end
        end else if (sclk_fall) begin
          // Chain mode passes the bit leaving the shift register; readback
          // mode shifts out the old input register followed by zeroes.
          sdo_next = sel_q ? ro_reg[15] : shift_reg[15];
        end
      end
      dacdb_pkg::DACDB_COMMIT: begin
        // Only a frame of at least sixteen bits reaches the input register.
        if (cnt_reg == dacdb_pkg::FRAME_BITS) begin
          in_next = shift_reg;
          commit = 1'b1;
        end else begin
          drop_next = 1'b1;
        end
        state_next = dacdb_pkg::DACDB_IDLE;
      end
      default: begin
        // An unused state code goes back to idle.
        state_next = dacdb_pkg::DACDB_IDLE;
      end
    endcase
  end

  // Output latch: transparent while the strobe is low, held while high.
  // Copying the registered input value, not the new one, covers strobe-low writes.
  // Modelled as a flop, so the code lags the input register by one cycle;
  // the analog stage cannot notice a single system cycle.
  always_comb begin
    latch_next = latch_reg;
    if (!ld_q) begin
      latch_next = in_reg;
    end
  end

  // Frame and buffer registers.
  // One register bank holds the whole frame state so the reset values sit together.
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_reg <= dacdb_pkg::DACDB_IDLE;
      shift_reg <= dacdb_pkg::CODE_RESET;
      in_reg <= dacdb_pkg::CODE_RESET;
      latch_reg <= dacdb_pkg::CODE_RESET;
      ro_reg <= dacdb_pkg::CODE_RESET;
      cnt_reg <= '0;
      sdo_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      in_reg <= in_next;
      latch_reg <= latch_next;
      ro_reg <= ro_next;
      cnt_reg <= cnt_next;
      sdo_reg <= sdo_next;
      drop_reg <= drop_next;
    end
  end

  // Outputs come straight from flops.
  assign dac_code = latch_reg;
  assign sdo = sdo_reg;
  assign frame_drop = drop_reg;

  // Committed words are logged; a full log drops the copy, never the update.
  // Gating on ready repeats the FIFO's own check but makes the dropped copy
  // visible at this level.
  assign fifo_push = commit && fifo_in_ready;
  dacdb_fifo #(
    .WIDTH(dacdb_pkg::WORD_W),
    .DEPTH(dacdb_pkg::FIFO_DEPTH)
  ) u_log (
    .mclk(mclk),
    .rst_n(rst_int_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(shift_reg),
    .out_valid(code_valid),
    .out_ready(code_ready),
    .out_data(code_data)
  );
endmodule
`default_nettype wire

// >>> rtl/dacdb_pkg.sv
// Shared constants for the double-buffered chained converter front end.
package dacdb_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    DACDB_IDLE = 2'b00,
    DACDB_SHIFT = 2'b01,
    DACDB_COMMIT = 2'b10
  } dacdb_state_t;
endpackage

// >>> rtl/dacdb_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module dacdb_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count updates.
  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Storage has no reset so it maps onto plain memory.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointer registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// >>> tb/dacdb_top_sva.sv
// Port-level checks on the converter front end.
`timescale 1ns/1ps
`default_nettype none
module dacdb_sva (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Watched pins and outputs.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic load_strobe_n,
  input wire logic serial_out_mode_select,
  input wire logic [15:0] dac_code,
  input wire logic code_valid,
  input wire logic [15:0] code_data,
  input wire logic frame_drop
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // The strobe is synchronised, so only a strobe settled high for a while must freeze the latch.
  AST_HOLD: assert property (load_strobe_n [*6] |-> $stable(dac_code))
    else $error("latch moved with strobe high");
  AST_IDLE: assert property (cs_n [*8] ##1 cs_n |-> !$rose(code_valid) && !frame_drop)
    else $error("commit while deselected");
  AST_COMMIT: assert property ($rose(cs_n) |-> ##[3:10] (code_valid || frame_drop))
    else $error("no commit after frame end");
  AST_KEEP: assert property (frame_drop |=> $stable(dac_code) [*3])
    else $error("short frame changed code");
  AST_SYNC: assert property ((!load_strobe_n) [*6] ##0 $rose(code_valid) |-> ##[0:4] dac_code == code_data)
    else $error("latch missed new word");
  AST_SDO: assert property ($changed(sdo) && !serial_out_mode_select |-> !sclk)
    else $error("sdo moved in high phase");
  AST_DROP: assert property (frame_drop |-> cs_n ##1 !frame_drop)
    else $error("bad drop pulse");
  AST_CODE: assert property ($changed(dac_code) |-> cs_n)
    else $error("code moved mid frame");
endmodule
bind dacdb_top dacdb_sva u_sva (.mclk, .rst_n, .cs_n, .sclk, .sdo, .load_strobe_n,
  .serial_out_mode_select, .dac_code, .code_valid, .code_data, .frame_drop);
`default_nettype wire

// >>> tb/dacdb_host.sv
// Host serial controller model that frames words onto the link.
`timescale 1ns/1ps
`default_nettype none
module dacdb_host (
  // Link pins.
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  logic [31:0] rx = 32'h00000000;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Clock idles low between frames; sdi flips on release so stale data never looks valid.
  task automatic frame(input logic [31:0] w, input int n, input int stray);
    #3;
    cs_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #40;
      rx = {rx[30:0], sdo};
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (stray) begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #240;
  endtask
endmodule
`default_nettype wire

// >>> tb/dacdb_top_bench.sv
// Self-checking bench for the converter front end.
`timescale 1ns/1ps
`default_nettype none
module dacdb_top_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic load_strobe_n = 1'b0;
  logic serial_out_mode_select = 1'b0;
  logic code_ready = 1'b0;
  wire cs_n, sclk, sdi, sdo, code_valid, frame_drop;
  wire [15:0] dac_code, code_data;
  logic [15:0] q[$];
  logic [15:0] cur;
  logic [31:0] w;
  int n_fail = 0;
  int n_compared = 0;
  int drops = 0;
  always #4 mclk = ~mclk;
  dacdb_top u_dacdb_top (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .load_strobe_n(load_strobe_n), .serial_out_mode_select(serial_out_mode_select),
    .dac_code(dac_code), .code_valid(code_valid), .code_ready(code_ready),
    .code_data(code_data), .frame_drop(frame_drop));
  dacdb_host u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  // The drop pulse lasts one cycle, so it is sampled every cycle.
  always @(negedge mclk) if (frame_drop === 1'b1) drops++;
  // Bits beyond sixteen leave in the order they entered.
  function automatic logic [15:0] first16(input logic [31:0] v);
    return v[31:16];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(23603));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    // Strobe low with a stalled consumer: eighteen words overfill the sixteen-deep log.
    for (int i = 0; i < 18; i++) begin
      @(posedge mclk);
      serial_out_mode_select <= i[0];
      w = $urandom;
      u_host.frame(w, 16, 0);
      check(dac_code, w[15:0]);
      if (i[0]) check(u_host.rx[15:0], cur);
      if (q.size() < 16) q.push_back(w[15:0]);
      cur = w[15:0];
    end
    // Strobe high: a long chained frame plus stray clocks must not touch the latch.
    @(posedge mclk);
    load_strobe_n <= 1'b1;
    serial_out_mode_select <= 1'b0;
    w = $urandom;
    u_host.frame(w, 32, 8);
    check(dac_code, cur);
    check(u_host.rx[15:0], first16(w));
    @(posedge mclk);
    load_strobe_n <= 1'b0;
    repeat (8) @(posedge mclk);
    check(dac_code, w[15:0]);
    cur = w[15:0];
    u_host.frame(32'h000000A5, 8, 0);
    check(dac_code, cur);
    check(16'(drops), 16'h0001);
    // Drain against a randomly stalling consumer; order must match the writes.
    repeat (300) begin
      @(posedge mclk);
      code_ready <= 1'($urandom);
      @(negedge mclk);
      if (code_valid === 1'b1 && code_ready === 1'b1) check(code_data, q.pop_front());
    end
    check(16'(q.size()), 16'h0000);
    check(16'(code_valid), 16'h0000);
    @(posedge mclk);
    code_ready <= 1'b0;
    w = $urandom;
    u_host.frame(w, 16, 0);
    check(code_data, w[15:0]);
    test_done;
  end
  // The run needs about 40 us; a hang is cut at 200 us.
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
